// ---- logic/gpc_pkg.sv ----
// constants and types for the four-pin configuration block
// assumes a 32-bit axi4-lite register bus and word-aligned registers
package gpc_pkg;

  // ****************************************************************
  // register indices and byte addresses
  // ****************************************************************
  localparam logic [7:0]  CFG_IDX_5_3 = 8'hCB;
  localparam logic [7:0]  CFG_IDX_5_4 = 8'hCC;
  localparam logic [7:0]  CFG_IDX_6_0 = 8'hD0;
  localparam logic [7:0]  CFG_IDX_6_1 = 8'hD1;
  localparam logic [11:0] ADDR_CFG_5_3 = {2'h0, CFG_IDX_5_3, 2'h0};
  localparam logic [11:0] ADDR_CFG_5_4 = {2'h0, CFG_IDX_5_4, 2'h0};
  localparam logic [11:0] ADDR_CFG_6_0 = {2'h0, CFG_IDX_6_0, 2'h0};
  localparam logic [11:0] ADDR_CFG_6_1 = {2'h0, CFG_IDX_6_1, 2'h0};
  localparam logic [11:0] ADDR_DATA    = 12'h400;
  localparam logic [11:0] ADDR_STATUS  = 12'h404;
  localparam logic [11:0] ADDR_MASK    = 12'h408;

  // ****************************************************************
  // field layouts and reset values
  // ****************************************************************
  localparam int         NUM_PINS     = 4;
  localparam logic [7:0] CFG_RESET    = 8'h01;
  localparam logic [7:0] CFG_WMASK    = 8'hBB;
  localparam logic [2:0] STAT_RESET   = 3'h0;
  localparam logic [2:0] MASK_RESET   = 3'h0;
  localparam logic [3:0] DATA_RESET   = 4'h0;
  localparam int         ST_EDGE_5_3  = 0;
  localparam int         ST_EDGE_5_4  = 1;
  localparam int         ST_GROUP     = 2;
  localparam logic [1:0] FSEL_ALT     = 2'h0;
  localparam logic [1:0] FSEL_IRQ     = 2'h1;
  localparam logic [1:0] FSEL_GPIO    = 2'h2;
  localparam logic [1:0] FSEL_SPECIAL = 2'h3;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  // one pin configuration register
  typedef struct packed {
    logic       open_drain;
    logic       rsvd6;
    logic       group_en;
    logic [1:0] fsel;
    logic       rsvd2;
    logic       invert;
    logic       dir_in;
  } gpc_cfg_t;

  typedef enum logic [1:0] {
    W_IDLE = 2'b01,
    W_RESP = 2'b10
  } gpc_wr_st_t;

  typedef enum logic [1:0] {
    R_IDLE = 2'b01,
    R_DATA = 2'b10
  } gpc_rd_st_t;

endpackage

// ---- logic/gpc_top.sv ----
// configuration and pin logic for pins 5.3, 5.4, 6.0 and 6.1
// assumes pin inputs and function sources are synchronous to ref_clk
`timescale 1ns/1ns

// Functional notes
// - config bit 0 high makes the pin input, low makes it output
// - config bit 1 high inverts pin value, low passes it unchanged
// - pin 5.3 selects rom chip select, irq11, gpio, either-edge irq 3
// - pin 5.4 selects rom output enable, irq12, gpio, either-edge irq 4
// - pin 6.0 selects parallel data 0, irq1, gpio, smi output
// - pin 6.1 selects parallel data 1, irq3, gpio, led output
// - config bit 5 adds the pin to combined group interrupt 2 when the pin selects gpio
// - config bit 7 high gives open drain, low gives push-pull
// - every configuration register resets to 0x01
module gpc_top #(
  parameter int AW = 12
) (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  // axi4-lite write address and data
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [AW-1:0]        s_axi_awaddr,
  input  wire logic [2:0]           s_axi_awprot,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  // axi4-lite write response
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  output logic [1:0]                s_axi_bresp,
  // axi4-lite read
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  input  wire logic [AW-1:0]        s_axi_araddr,
  input  wire logic [2:0]           s_axi_arprot,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  // pins, index 0..3 = 5.3, 5.4, 6.0, 6.1
  input  wire logic [3:0]           pin_in,
  output logic [3:0]                pin_out,
  output logic [3:0]                pin_oe_n,
  // alternate function sources
  input  wire logic                 boot_rom_chip_select_n,
  input  wire logic                 boot_rom_output_enable_n,
  input  wire logic                 parallel_data_bit0,
  input  wire logic                 parallel_data_bit1,
  input  wire logic                 system_mgmt_interrupt_out_n,
  input  wire logic                 led_drive,
  // alternate function results
  output logic [1:0]                parallel_data_in,
  output logic [3:0]                irq_line_req,
  output logic                      group_irq2_req,
  output logic                      irq
);

  // ****************************************************************
  // address decoding helpers
  // ****************************************************************

  // word match of a bus address against a register address
  function automatic logic gpc_hit(input logic [AW-1:0] a,
                                   input logic [11:0]   r);
    gpc_hit = (a[AW-1:2] == r[AW-1:2]);
  endfunction

  // config register select: {hit, index}
  function automatic logic [2:0] gpc_cfg_sel(input logic [AW-1:0] a);
    if (gpc_hit(a, gpc_pkg::ADDR_CFG_5_3)) begin
      gpc_cfg_sel = 3'h4;
    end else if (gpc_hit(a, gpc_pkg::ADDR_CFG_5_4)) begin
      gpc_cfg_sel = 3'h5;
    end else if (gpc_hit(a, gpc_pkg::ADDR_CFG_6_0)) begin
      gpc_cfg_sel = 3'h6;
    end else if (gpc_hit(a, gpc_pkg::ADDR_CFG_6_1)) begin
      gpc_cfg_sel = 3'h7;
    end else begin
      gpc_cfg_sel = 3'h0;
    end
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  gpc_pkg::gpc_cfg_t   cfg [gpc_pkg::NUM_PINS];
  gpc_pkg::gpc_wr_st_t wr_st;
  gpc_pkg::gpc_rd_st_t rd_st;
  logic                aw_held;
  logic                w_held;
  logic [AW-1:0]       wr_addr;
  logic [7:0]          wr_data;
  logic                wr_lane0;
  logic [3:0]          gpio_data;
  logic [2:0]          status;
  logic [2:0]          mask;
  logic [3:0]          pin_prev;
  logic                group_prev;

  // ****************************************************************
  // axi4-lite write path
  // ****************************************************************
  logic       do_write;
  logic [2:0] wr_cfg_sel;
  logic       wr_data_hit;
  logic       wr_mask_hit;
  logic       wr_stat_hit;
  logic       wr_ok;

  // handshakes and write decode
  assign s_axi_awready = (wr_st == gpc_pkg::W_IDLE) && !aw_held;
  assign s_axi_wready  = (wr_st == gpc_pkg::W_IDLE) && !w_held;
  assign s_axi_bvalid  = (wr_st == gpc_pkg::W_RESP);
  assign do_write      = (wr_st == gpc_pkg::W_IDLE) && aw_held && w_held;
  assign wr_cfg_sel    = gpc_cfg_sel(wr_addr);
  assign wr_data_hit   = gpc_hit(wr_addr, gpc_pkg::ADDR_DATA);
  assign wr_mask_hit   = gpc_hit(wr_addr, gpc_pkg::ADDR_MASK);
  assign wr_stat_hit   = gpc_hit(wr_addr, gpc_pkg::ADDR_STATUS);
  assign wr_ok         = wr_cfg_sel[2] || wr_data_hit || wr_mask_hit
                         || wr_stat_hit;

  // write channel state machine
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wr_st       <= gpc_pkg::W_IDLE;
      aw_held     <= 1'b0;
      w_held      <= 1'b0;
      wr_addr     <= '0;
      wr_data     <= 8'h00;
      wr_lane0    <= 1'b0;
      s_axi_bresp <= gpc_pkg::RESP_OKAY;
    end else begin
      case (wr_st)
        gpc_pkg::W_IDLE: begin
          if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            wr_addr <= s_axi_awaddr;
          end
          if (s_axi_wvalid && s_axi_wready) begin
            w_held   <= 1'b1;
            wr_data  <= s_axi_wdata[7:0];
            wr_lane0 <= s_axi_wstrb[0];
          end
          if (do_write) begin
            wr_st       <= gpc_pkg::W_RESP;
            s_axi_bresp <= wr_ok ? gpc_pkg::RESP_OKAY
                                 : gpc_pkg::RESP_SLVERR;
          end
        end
        gpc_pkg::W_RESP: begin
          if (s_axi_bready) begin
            wr_st   <= gpc_pkg::W_IDLE;
            aw_held <= 1'b0;
            w_held  <= 1'b0;
          end
        end
        default: begin
          wr_st <= gpc_pkg::W_IDLE;
        end
      endcase
    end
  end

  // configuration registers, reserved bits forced low
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < gpc_pkg::NUM_PINS; i++) begin
        cfg[i] <= gpc_pkg::CFG_RESET;
      end
    end else if (do_write && wr_lane0 && wr_cfg_sel[2]) begin
      cfg[wr_cfg_sel[1:0]] <= wr_data & gpc_pkg::CFG_WMASK;
    end
  end

  // gpio output data and interrupt mask
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      gpio_data <= gpc_pkg::DATA_RESET;
      mask      <= gpc_pkg::MASK_RESET;
    end else if (do_write && wr_lane0) begin
      if (wr_data_hit) begin
        gpio_data <= wr_data[3:0];
      end
      if (wr_mask_hit) begin
        mask <= wr_data[2:0];
      end
    end
  end

  // ****************************************************************
  // axi4-lite read path
  // ****************************************************************
  logic        rd_take;
  logic [2:0]  rd_cfg_sel;
  logic        rd_stat_hit;
  logic [31:0] rd_word;
  logic        rd_ok;
  logic [3:0]  pin_val;

  assign s_axi_arready = (rd_st == gpc_pkg::R_IDLE);
  assign s_axi_rvalid  = (rd_st == gpc_pkg::R_DATA);
  assign rd_take       = s_axi_arvalid && s_axi_arready;
  assign rd_cfg_sel    = gpc_cfg_sel(s_axi_araddr);
  assign rd_stat_hit   = gpc_hit(s_axi_araddr, gpc_pkg::ADDR_STATUS);

  // read data select, unmapped reads return zero
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (rd_cfg_sel[2]) begin
      rd_word[7:0] = cfg[rd_cfg_sel[1:0]];
    end else if (gpc_hit(s_axi_araddr, gpc_pkg::ADDR_DATA)) begin
      rd_word[7:0] = {pin_val, gpio_data};
    end else if (rd_stat_hit) begin
      rd_word[2:0] = status;
    end else if (gpc_hit(s_axi_araddr, gpc_pkg::ADDR_MASK)) begin
      rd_word[2:0] = mask;
    end else begin
      rd_ok = 1'b0;
    end
  end

  // read channel state machine
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_st       <= gpc_pkg::R_IDLE;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= gpc_pkg::RESP_OKAY;
    end else begin
      case (rd_st)
        gpc_pkg::R_IDLE: begin
          if (rd_take) begin
            rd_st       <= gpc_pkg::R_DATA;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? gpc_pkg::RESP_OKAY
                                 : gpc_pkg::RESP_SLVERR;
          end
        end
        gpc_pkg::R_DATA: begin
          if (s_axi_rready) begin
            rd_st <= gpc_pkg::R_IDLE;
          end
        end
        default: begin
          rd_st <= gpc_pkg::R_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // pin function multiplexing
  // ****************************************************************
  logic [3:0] alt_src;
  logic [3:0] special_src;
  logic [3:0] drv_src;
  logic [3:0] drv_val;
  logic [3:0] next_pin_out;
  logic [3:0] next_oe_n;
  logic [3:0] irq_sel;
  logic [3:0] group_mem;
  logic [3:0] edge_hit;
  logic       group_now;

  // code 00 and code 11 output sources per pin
  assign alt_src     = {parallel_data_bit1, parallel_data_bit0,
                        boot_rom_output_enable_n,
                        boot_rom_chip_select_n};
  assign special_src = {led_drive, system_mgmt_interrupt_out_n,
                        2'b00};

  genvar g;
  generate
    for (g = 0; g < gpc_pkg::NUM_PINS; g++) begin : pin_g
      // input path with optional inversion
      assign pin_val[g] = pin_in[g] ^ cfg[g].invert;
      // source for the selected function
      assign drv_src[g] =
        (cfg[g].fsel == gpc_pkg::FSEL_ALT)     ? alt_src[g] :
        (cfg[g].fsel == gpc_pkg::FSEL_SPECIAL) ? special_src[g] :
        gpio_data[g];
      assign drv_val[g] = drv_src[g] ^ cfg[g].invert;
      // open drain only pulls low, push-pull drives both levels
      assign next_pin_out[g] = cfg[g].open_drain ? 1'b0
                                                 : drv_val[g];
      assign next_oe_n[g] = cfg[g].dir_in
        || (cfg[g].open_drain && drv_val[g]);
      assign irq_sel[g]   = (cfg[g].fsel == gpc_pkg::FSEL_IRQ)
                            && cfg[g].dir_in;
      assign group_mem[g] = cfg[g].group_en
                            && (cfg[g].fsel == gpc_pkg::FSEL_GPIO)
                            && pin_val[g];
      assign edge_hit[g]  = (cfg[g].fsel == gpc_pkg::FSEL_SPECIAL)
                            && (pin_val[g] != pin_prev[g]);
    end
  endgenerate

  assign group_now = |group_mem;

  // registered pin drive and function outputs
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_out          <= 4'h0;
      pin_oe_n         <= 4'hF;
      irq_line_req     <= 4'h0;
      parallel_data_in <= 2'h0;
      group_irq2_req   <= 1'b0;
    end else begin
      pin_out          <= next_pin_out;
      pin_oe_n         <= next_oe_n;
      irq_line_req     <= pin_val & irq_sel;
      parallel_data_in <= pin_val[3:2];
      group_irq2_req   <= group_now;
    end
  end

  // ****************************************************************
  // interrupt status, mask and output
  // ****************************************************************
  logic [2:0] events;
  logic [2:0] next_status;

  // either-edge events on 5.3/5.4 and rising group interrupt
  assign events[gpc_pkg::ST_EDGE_5_3] = edge_hit[0];
  assign events[gpc_pkg::ST_EDGE_5_4] = edge_hit[1];
  assign events[gpc_pkg::ST_GROUP]    = group_now && !group_prev;
  // read clears, a new event in the same cycle wins
  assign next_status = ((rd_take && rd_stat_hit) ? 3'h0 : status)
                       | events;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      status     <= gpc_pkg::STAT_RESET;
      pin_prev   <= 4'h0;
      group_prev <= 1'b0;
      irq        <= 1'b0;
    end else begin
      status     <= next_status;
      pin_prev   <= pin_val;
      group_prev <= group_now;
      irq        <= |(next_status & mask);
    end
  end

endmodule

// ---- verification/gpc_board.sv ----
// board side of the four configurable pins
// assumes a pull-up on every pin and an optional bench driver
`timescale 1ns/1ns
module gpc_board (
  // drive from the block
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe_n,
  // external driver set by the bench
  input  wire logic [3:0] ext_en,
  input  wire logic [3:0] ext_val,
  // resolved pin levels
  output logic [3:0]      pin_in
);
  // block drive wins, then the external driver, then the pull-up
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_in[i] = !pin_oe_n[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : 1'h1;
    end
  end
endmodule

// ---- verification/gpc_top_checker.sv ----
// protocol and pin checks for the configuration block
// assumes it is bound onto gpc_top, one clock domain
`timescale 1ns/1ns
module gpc_top_checker #(
  parameter int AW = 12
) (
  // clock and reset
  input wire logic          ref_clk,
  input wire logic          rst_n,
  // bus handshakes
  input wire logic          s_axi_awvalid,
  input wire logic          s_axi_awready,
  input wire logic          s_axi_wvalid,
  input wire logic          s_axi_wready,
  input wire logic          s_axi_bvalid,
  input wire logic          s_axi_bready,
  input wire logic          s_axi_arvalid,
  input wire logic          s_axi_arready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic          s_axi_rvalid,
  input wire logic          s_axi_rready,
  input wire logic [31:0]   s_axi_rdata,
  // pins and requests
  input wire logic [3:0]    pin_oe_n,
  input wire logic [3:0]    irq_line_req,
  input wire logic          irq
);
  // ****************************************
  // helper logic and assertions
  // ****************************************
  logic        cfg_rd; // read in flight aims at a config register
  wire  [11:0] ra = 12'(s_axi_araddr);
  wire         ra_cfg = ra == gpc_pkg::ADDR_CFG_5_3 ||
                        ra == gpc_pkg::ADDR_CFG_5_4 ||
                        ra == gpc_pkg::ADDR_CFG_6_0 ||
                        ra == gpc_pkg::ADDR_CFG_6_1;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // remember the kind of the accepted read address
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cfg_rd <= 1'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      cfg_rd <= ra_cfg;
    end
  end
  a_reset_pins: assert property (
    $rose(rst_n) |-> pin_oe_n == 4'hF && !irq)
    else $error("pins not inputs after reset");
  a_bus_idle: assert property (
    $rose(rst_n) |-> s_axi_awready && s_axi_wready && s_axi_arready &&
      !s_axi_bvalid && !s_axi_rvalid)
    else $error("bus not idle after reset");
  a_write_resp: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_bresp_holds: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_write_busy: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not one cycle later");
  a_read_holds: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_rsvd_zero: assert property (
    s_axi_rvalid && cfg_rd |-> (s_axi_rdata & 32'hFFFFFF44) == 32'h0)
    else $error("reserved config bits read nonzero");
  a_irq_input: assert property (
    (irq_line_req & ~pin_oe_n) == 4'h0)
    else $error("irq request on a driven pin");
endmodule

bind gpc_top gpc_top_checker #(.AW(AW)) u_gpc_chk (
  .ref_clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .pin_oe_n, .irq_line_req, .irq);

// ---- verification/gpc_top_tb_top.sv ----
// self-checking bench for the pin configuration block
// assumes gpc_top, gpc_board and the bound checker are compiled
`timescale 1ns/1ns
module gpc_top_tb_top;
  logic        ref_clk = 1'h0;
  logic        rst_n = 1'h0;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, group_irq2_req, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, parallel_data_in;
  logic [3:0]  pin_in, pin_out, pin_oe_n, irq_line_req, ext_en, ext_val;
  logic [5:0]  src;
  logic [1:0]  bresp_seen;
  int          n_fail = 0;
  int          num_checks = 0;
  logic [11:0] cfg_addr [4] = '{gpc_pkg::ADDR_CFG_5_3,
    gpc_pkg::ADDR_CFG_5_4, gpc_pkg::ADDR_CFG_6_0, gpc_pkg::ADDR_CFG_6_1};
  logic [7:0]  gp_cfg [3] = '{8'h10, 8'h12, 8'h90};
  logic [7:0]  gp_exp [3] = '{8'h05, 8'h0A, 8'h50};
  logic [7:0]  in_cfg [4] = '{8'h09, 8'h0B, 8'h01, 8'h03};
  logic [3:0]  in_exp [4] = '{4'h6, 4'h9, 4'h1, 4'h2};
  logic [3:0]  eg_val [3] = '{4'h7, 4'h5, 4'h4};
  logic [2:0]  eg_exp [3] = '{3'h5, 3'h2, 3'h5};

  always #25 ref_clk = ~ref_clk;

  gpc_top dut (.ref_clk, .rst_n, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .pin_in, .pin_out, .pin_oe_n,
    .boot_rom_chip_select_n(src[0]), .boot_rom_output_enable_n(src[1]),
    .parallel_data_bit0(src[2]), .parallel_data_bit1(src[3]),
    .system_mgmt_interrupt_out_n(src[4]), .led_drive(src[5]),
    .parallel_data_in, .irq_line_req, .group_irq2_req, .irq);
  gpc_board u_board (.pin_out, .pin_oe_n, .ext_en, .ext_val, .pin_in);

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one write, address and data offered together
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw_hs, w_hs, b_hs;
    int   n;
    n = 0;
    @(posedge ref_clk);
    s_axi_awvalid <= 1'h1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'h1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'h1;
    do begin
      @(negedge ref_clk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      b_hs = s_axi_bvalid;
      bresp_seen = s_axi_bresp;
      @(posedge ref_clk);
      if (aw_hs) s_axi_awvalid <= 1'h0;
      if (w_hs) s_axi_wvalid <= 1'h0;
      n++;
    end while (!b_hs && n < 50);
    s_axi_bready <= 1'h0;
    if (!b_hs) n_fail++;
  endtask

  // one read, data and response taken at the handshake
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ar_hs, r_hs;
    int   n;
    n = 0;
    @(posedge ref_clk);
    s_axi_arvalid <= 1'h1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'h1;
    do begin
      @(negedge ref_clk);
      ar_hs = s_axi_arvalid && s_axi_arready;
      r_hs = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge ref_clk);
      if (ar_hs) s_axi_arvalid <= 1'h0;
      n++;
    end while (!r_hs && n < 50);
    s_axi_rready <= 1'h0;
    if (!r_hs) n_fail++;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp,
                      input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, exp);
    chk(32'(r), 32'(er));
  endtask

  // four config bytes, pin 5.3 in the low byte
  task automatic cfg4(input logic [31:0] v);
    for (int i = 0; i < 4; i++) wr(cfg_addr[i], {24'h0, v[8*i+:8]});
  endtask

  task automatic pins(input logic [3:0] v);
    @(posedge ref_clk);
    ext_en <= 4'hF;
    ext_val <= v;
  endtask

  task automatic settle;
    repeat (3) @(negedge ref_clk);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [3:0]  e;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    {s_axi_awprot, s_axi_arprot, s_axi_wstrb} = 10'h00F;
    {ext_en, ext_val, src} = 14'h0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'h1;
    rchk(gpc_pkg::ADDR_MASK, 32'h0, gpc_pkg::RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      rchk(cfg_addr[i], 32'h01, gpc_pkg::RESP_OKAY);
      wr(cfg_addr[i], 32'hFF);
      rchk(cfg_addr[i], 32'hBB, gpc_pkg::RESP_OKAY);
    end
    rchk(12'h010, 32'h0, gpc_pkg::RESP_SLVERR);
    wr(12'h010, 32'hFF);
    chk(32'(bresp_seen), 32'(gpc_pkg::RESP_SLVERR));
    // a write without lane 0 is answered but leaves the register alone
    s_axi_wstrb <= 4'hE;
    wr(cfg_addr[0], 32'h0);
    s_axi_wstrb <= 4'hF;
    chk(32'(bresp_seen), 32'(gpc_pkg::RESP_OKAY));
    rchk(cfg_addr[0], 32'hBB, gpc_pkg::RESP_OKAY);
    // alternate outputs: strobes, smi and led, then parallel data
    for (int k = 0; k < 2; k++) begin
      cfg4(k ? 32'h0 : 32'h1818_0000);
      @(posedge ref_clk);
      src <= k ? 6'h1A : 6'h25; // code 00 and 11 sources differ
      settle;
      e = {k ? src[3:2] : src[5:4], src[1:0]};
      chk(32'(pin_out), 32'(e));
    end
    // gpio outputs: plain, inverted, open drain
    for (int k = 0; k < 3; k++) begin
      cfg4({4{gp_cfg[k]}});
      wr(gpc_pkg::ADDR_DATA, 32'h5);
      settle;
      chk(32'({pin_oe_n, pin_out}), 32'(gp_exp[k]));
    end
    // inputs into irq lines and parallel data, plain and inverted
    pins(4'h6);
    for (int k = 0; k < 4; k++) begin
      cfg4({4{in_cfg[k]}});
      settle;
      e = k < 2 ? irq_line_req : {2'h0, parallel_data_in};
      chk(32'(e), 32'(in_exp[k]));
    end
    // inverted pin levels above the gpio output bits
    rchk(gpc_pkg::ADDR_DATA, 32'h95, gpc_pkg::RESP_OKAY);
    // either-edge events on 5.3 and 5.4, only 5.3 unmasked
    cfg4(32'h0101_1919);
    wr(gpc_pkg::ADDR_MASK, 32'h1);
    rd(gpc_pkg::ADDR_STATUS, d, r);
    for (int k = 0; k < 3; k++) begin
      pins(eg_val[k]);
      settle;
      chk(32'(irq), 32'(eg_exp[k][2]));
      rchk(gpc_pkg::ADDR_STATUS, 32'(eg_exp[k][1:0]), gpc_pkg::RESP_OKAY);
    end
    settle;
    chk(32'(irq), 32'h0);
    // group enable on 6.0 set, then cleared
    for (int k = 0; k < 2; k++) begin
      cfg4(k ? 32'h0111_0101 : 32'h0131_0101);
      settle;
      chk(32'(group_irq2_req), 32'(k == 0));
    end
    report_and_stop;
  end

  // watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    report_and_stop;
  end
endmodule
